// ===== qgpo_map.svh
`ifndef QGPO_MAP_SVH
`define QGPO_MAP_SVH

// Clock period of mclk
`define QGPO_CLK_NS 100

// Resolution select codes
`define QGPO_RES_0P5UM 2'h0
`define QGPO_RES_1UM 2'h1
`define QGPO_RES_5UM 2'h2

// Least edge intervals, rounded up to whole cycles
`define QGPO_TR_0P5_NS 1000
`define QGPO_TR_1_NS 500
`define QGPO_TR_5_NS 1000
`define QGPO_TB_NS 200
`define QGPO_TE_NS 200
`define QGPO_TR_0P5_CYC ((`QGPO_TR_0P5_NS + `QGPO_CLK_NS - 1) / `QGPO_CLK_NS)
`define QGPO_TR_1_CYC ((`QGPO_TR_1_NS + `QGPO_CLK_NS - 1) / `QGPO_CLK_NS)
`define QGPO_TR_5_CYC ((`QGPO_TR_5_NS + `QGPO_CLK_NS - 1) / `QGPO_CLK_NS)
`define QGPO_TB_CYC ((`QGPO_TB_NS + `QGPO_CLK_NS - 1) / `QGPO_CLK_NS)
`define QGPO_TE_CYC ((`QGPO_TE_NS + `QGPO_CLK_NS - 1) / `QGPO_CLK_NS)

// Longest catch-up delays, rounded down to whole cycles
`define QGPO_RT3_DLY_NS 1000
`define QGPO_RT2_DLY_NS 2500
`define QGPO_BST1_DLY_NS 5000
`define QGPO_BST2_DLY_NS 10000
`define QGPO_RT3_DLY_CYC (`QGPO_RT3_DLY_NS / `QGPO_CLK_NS)
`define QGPO_RT2_DLY_CYC (`QGPO_RT2_DLY_NS / `QGPO_CLK_NS)
`define QGPO_BST1_DLY_CYC (`QGPO_BST1_DLY_NS / `QGPO_CLK_NS)
`define QGPO_BST2_DLY_CYC (`QGPO_BST2_DLY_NS / `QGPO_CLK_NS)

// Reset values
`define QGPO_POS_RST 16'h0000

`endif

// ===== qgpo_pkg.sv
package qgpo_pkg;

    typedef enum logic [2:0] {
        QGPO_RT = 3'h1,
        QGPO_BURST = 3'h2,
        QGPO_ERR = 3'h4
    } qgpo_mode_e;

    typedef logic [15:0] qgpo_pos_t;

    // Differential channel pairs, true polarity only, plus the single-ended alarm line
    typedef struct packed {
        logic pa;
        logic pb;
        logic pz;
        logic alarm;
    } qgpo_line_s;

    typedef struct packed {
        qgpo_mode_e mode;
        qgpo_pos_t target;
        qgpo_pos_t out_pos;
        logic [7:0] tmr;
        logic rev;
        logic last_dir;
        logic err_lvl;
        qgpo_line_s line;
    } qgpo_state_s;

    typedef struct packed {
        logic [7:0] cnt;
    } qgpo_spc_state_s;

endpackage

// ===== qgpo_spacer.sv
`timescale 1ns/1ps
`default_nettype none

// Counts cycles since the last emitted edge; ready once the limit is met
module qgpo_spacer
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_sync_b,
    // Edge in, spacing out
    input wire logic edge_p,
    input wire logic [7:0] limit,
    output logic ready
);

    qgpo_pkg::qgpo_spc_state_s st_reg;
    qgpo_pkg::qgpo_spc_state_s st_next;

    always_comb
    begin
        st_next = st_reg;
        if (edge_p)
        begin
            st_next.cnt = 8'h01;
        end
        else if (st_reg.cnt != 8'hFF)
        begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            // Start saturated so the first edge is not held back
            st_reg <= '{cnt: 8'hFF};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign ready = (st_reg.cnt >= limit);

endmodule

`default_nettype wire

// ===== qgpo_gen.sv
// Summary of operation
// - Drive A and B square waves a quarter period apart.
// - A leads B on retraction, B leads A on extension.
// - One quadrature period spans four resolution steps.
// - Real-time edges follow the spindle, spaced by the real-time interval.
// - Three-mode real-time output catches up within 1us.
// - Beyond the real-time limit, emit clocked burst edges at shorter spacing.
// - Burst catches up within 5us one way, 10us with reversal.
// - Overspeed or disturbance enters error mode with A and B in step.
// - Error-mode pulses last at least the error minimum width.
// - Two-mode group has no burst, catches up within 2.5us.
// - Two-mode group enters error mode on overspeed or disturbance.
// - Output delay is time until emitted count matches the position.
// - Alarm condition produces the same error-mode pattern on the outputs as a disturbance.
// - Origin variant adds a differential origin-mark channel.
// - Factory option adds a separate alarm line.
`timescale 1ns/1ps
`include "qgpo_map.svh"
`default_nettype none

module qgpo_gen
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Configuration straps
    input wire logic three_mode,
    input wire logic [1:0] res_sel,
    input wire logic origin_en,
    input wire logic alarm_line_en,
    input wire logic [15:0] origin_pos,
    // Detector events
    input wire logic pos_step,
    input wire logic pos_extend,
    input wire logic disturb,
    input wire logic alarm_in,
    // Differential line outputs and single-ended alarm line
    output logic pha_p,
    output logic pha_n,
    output logic phb_p,
    output logic phb_n,
    output logic phz_p,
    output logic phz_n,
    output logic alarm_out,
    // Status
    output logic err_mode
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_pipe;
    logic rst_sync_b;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////
    qgpo_pkg::qgpo_state_s st_reg;
    qgpo_pkg::qgpo_state_s st_next;
    logic edge_p;
    logic sp_ready;
    logic [7:0] limit;
    logic [15:0] gap;
    logic bad;

    qgpo_spacer u_spacer
    (
        .mclk(mclk),
        .rst_sync_b(rst_sync_b),
        .edge_p(edge_p),
        .limit(limit),
        .ready(sp_ready)
    );

    // Edge spacing per mode and resolution
    always_comb
    begin
        limit = 8'(`QGPO_TR_1_CYC);
        if (st_reg.mode == qgpo_pkg::QGPO_ERR)
        begin
            limit = 8'(`QGPO_TE_CYC);
        end
        else if (st_reg.mode == qgpo_pkg::QGPO_BURST)
        begin
            limit = 8'(`QGPO_TB_CYC);
        end
        else if (res_sel == `QGPO_RES_0P5UM)
        begin
            limit = 8'(`QGPO_TR_0P5_CYC);
        end
        else if (res_sel == `QGPO_RES_5UM)
        begin
            limit = 8'(`QGPO_TR_5_CYC);
        end
    end

    // Gap is the unemitted count; its age is the output delay
    assign gap = st_reg.target - st_reg.out_pos;
    assign bad = disturb | alarm_in;

    always_comb
    begin
        st_next = st_reg;
        edge_p = 1'b0;
        // Retraction counts up so that A leads
        if (pos_step)
        begin
            st_next.target = pos_extend ? st_reg.target - 16'h0001
                                        : st_reg.target + 16'h0001;
            st_next.last_dir = pos_extend;
            if (gap != 16'h0000 && pos_extend != st_reg.last_dir)
            begin
                st_next.rev = 1'b1;
            end
        end
        if (gap == 16'h0000)
        begin
            st_next.tmr = 8'h00;
            st_next.rev = 1'b0;
        end
        else if (st_reg.tmr != 8'hFF)
        begin
            st_next.tmr = st_reg.tmr + 8'h01;
        end
        case (st_reg.mode)
            qgpo_pkg::QGPO_RT:
            begin
                if (bad)
                begin
                    st_next.mode = qgpo_pkg::QGPO_ERR;
                    st_next.err_lvl = 1'b0;
                    edge_p = 1'b1;
                end
                else if (three_mode && st_reg.tmr >= 8'(`QGPO_RT3_DLY_CYC))
                begin
                    st_next.mode = qgpo_pkg::QGPO_BURST;
                end
                else if (!three_mode &&
                         st_reg.tmr >= 8'(`QGPO_RT2_DLY_CYC))
                begin
                    st_next.mode = qgpo_pkg::QGPO_ERR;
                    st_next.err_lvl = 1'b0;
                    edge_p = 1'b1;
                end
                else if (sp_ready && gap != 16'h0000)
                begin
                    st_next.out_pos = gap[15] ? st_reg.out_pos - 16'h0001
                                              : st_reg.out_pos + 16'h0001;
                    edge_p = 1'b1;
                end
            end
            qgpo_pkg::QGPO_BURST:
            begin
                if (bad || st_reg.tmr >= (st_reg.rev ?
                        8'(`QGPO_BST2_DLY_CYC) : 8'(`QGPO_BST1_DLY_CYC)))
                begin
                    st_next.mode = qgpo_pkg::QGPO_ERR;
                    st_next.err_lvl = 1'b0;
                    edge_p = 1'b1;
                end
                else if (gap == 16'h0000)
                begin
                    st_next.mode = qgpo_pkg::QGPO_RT;
                end
                else if (sp_ready)
                begin
                    st_next.out_pos = gap[15] ? st_reg.out_pos - 16'h0001
                                              : st_reg.out_pos + 16'h0001;
                    edge_p = 1'b1;
                end
            end
            qgpo_pkg::QGPO_ERR:
            begin
                // Leave only from a low level so no pulse is cut short
                if (sp_ready)
                begin
                    if (!bad && !st_reg.err_lvl)
                    begin
                        st_next.mode = qgpo_pkg::QGPO_RT;
                        st_next.out_pos = st_next.target;
                        st_next.tmr = 8'h00;
                        st_next.rev = 1'b0;
                    end
                    else
                    begin
                        st_next.err_lvl = ~st_reg.err_lvl;
                    end
                    edge_p = 1'b1;
                end
            end
            default:
            begin
                st_next.mode = qgpo_pkg::QGPO_ERR;
            end
        endcase
        // Line levels, error pattern forces A and B together
        if (st_next.mode == qgpo_pkg::QGPO_ERR)
        begin
            st_next.line.pa = st_next.err_lvl;
            st_next.line.pb = st_next.err_lvl;
            st_next.line.pz = 1'b0;
        end
        else
        begin
            st_next.line.pa = st_next.out_pos[1] ^ st_next.out_pos[0];
            st_next.line.pb = st_next.out_pos[1];
            st_next.line.pz = origin_en &&
                              (st_next.out_pos == origin_pos);
        end
        st_next.line.alarm = alarm_line_en &&
                             (st_next.mode == qgpo_pkg::QGPO_ERR);
    end

    always_ff @(posedge mclk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            st_reg <= '{mode: qgpo_pkg::QGPO_RT, target: `QGPO_POS_RST,
                        out_pos: `QGPO_POS_RST, tmr: 8'h00, rev: 1'b0,
                        last_dir: 1'b0, err_lvl: 1'b0,
                        line: '{pa: 1'b0, pb: 1'b0, pz: 1'b0, alarm: 1'b0}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign pha_p = st_reg.line.pa;
    assign pha_n = ~st_reg.line.pa;
    assign phb_p = st_reg.line.pb;
    assign phb_n = ~st_reg.line.pb;
    assign phz_p = st_reg.line.pz;
    assign phz_n = ~st_reg.line.pz;
    assign alarm_out = st_reg.line.alarm;
    assign err_mode = (st_reg.mode == qgpo_pkg::QGPO_ERR);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_quad_one_bit: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (st_reg.mode != qgpo_pkg::QGPO_ERR &&
         $past(st_reg.mode) != qgpo_pkg::QGPO_ERR) |->
        !($changed(st_reg.line.pa) && $changed(st_reg.line.pb)))
        else $error("both phases moved outside error mode");

    a_phase_map: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (st_reg.mode != qgpo_pkg::QGPO_ERR) |->
        (st_reg.line.pa == (st_reg.out_pos[1] ^ st_reg.out_pos[0]) &&
         st_reg.line.pb == st_reg.out_pos[1]))
        else $error("phase levels do not match count");

    a_edge_spacing: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (st_reg.mode == qgpo_pkg::QGPO_RT &&
         $changed(st_reg.out_pos)) |=> !$changed(st_reg.out_pos))
        else $error("real-time edges too close");

    a_rt_catchup: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (three_mode && st_reg.mode == qgpo_pkg::QGPO_RT && !bad &&
         st_reg.tmr >= 8'(`QGPO_RT3_DLY_CYC)) |=>
        (st_reg.mode == qgpo_pkg::QGPO_BURST))
        else $error("real-time delay exceeded without burst");

    a_burst_bound: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (st_reg.mode == qgpo_pkg::QGPO_BURST) |->
        (st_reg.tmr <= 8'(`QGPO_BST2_DLY_CYC)))
        else $error("burst catch-up too slow");

    a_err_sync: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (st_reg.mode == qgpo_pkg::QGPO_ERR) |->
        (st_reg.line.pa == st_reg.line.pb))
        else $error("phases not in step during error");

    a_err_width: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (st_reg.mode == qgpo_pkg::QGPO_ERR && $rose(st_reg.line.pa)) |=>
        st_reg.line.pa)
        else $error("error pulse shorter than minimum");

    a_no_burst2: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        !three_mode |=> (st_reg.mode != qgpo_pkg::QGPO_BURST ||
                         $past(st_reg.mode) == qgpo_pkg::QGPO_BURST))
        else $error("burst entered by two-mode group");

    a_alarm_entry: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        $rose(alarm_in) |-> ##[1:2] (st_reg.mode == qgpo_pkg::QGPO_ERR))
        else $error("alarm did not start error pattern");

    a_origin_mark: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (st_reg.line.pz) |-> (st_reg.out_pos == $past(origin_pos) ||
                              st_reg.out_pos == origin_pos))
        else $error("origin mark away from origin");

    a_alarm_line: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        alarm_out == (alarm_line_en && err_mode) ||
        alarm_line_en != $past(alarm_line_en))
        else $error("alarm line disagrees with error mode");

endmodule

`default_nettype wire

// ===== qgpo_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module qgpo_rx_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clr,
    // Line inputs
    input wire logic pha_p,
    input wire logic pha_n,
    input wire logic phb_p,
    input wire logic phb_n,
    // Decoded results
    output qgpo_pkg::qgpo_pos_t cnt,
    output logic err_seen,
    output logic pair_bad,
    output logic [7:0] min_gap
);
    logic [1:0] idx_reg;
    logic [1:0] idx_now;
    logic [7:0] gap_reg;

    // Gray position of (A,B): 00,10,11,01 runs upward
    assign idx_now = {phb_p, pha_p ^ phb_p};

    // Sampled every mclk, at twice the 5 Mcps burst edge rate
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            idx_reg <= 2'h0;
            cnt <= 16'h0000;
            err_seen <= 1'b0;
            pair_bad <= 1'b0;
            gap_reg <= 8'hFF;
            min_gap <= 8'hFF;
        end
        else if (clr)
        begin
            idx_reg <= idx_now;
            err_seen <= 1'b0;
            gap_reg <= 8'hFF;
            min_gap <= 8'hFF;
        end
        else
        begin
            idx_reg <= idx_now;
            if (pha_n !== ~pha_p || phb_n !== ~phb_p)
                pair_bad <= 1'b1;
            if (idx_now != idx_reg)
            begin
                gap_reg <= 8'h01;
                if (gap_reg < min_gap)
                    min_gap <= gap_reg;
                // Burst edges are counted like real-time ones
                if (idx_now - idx_reg == 2'h1)
                    cnt <= cnt + 16'h0001;
                else if (idx_now - idx_reg == 2'h3)
                    cnt <= cnt - 16'h0001;
                else
                    err_seen <= 1'b1;
            end
            else if (gap_reg != 8'hFF)
                gap_reg <= gap_reg + 8'h01;
        end
    end
endmodule

`default_nettype wire

// ===== tb_qgpo_gen.sv
`timescale 1ns/1ps
`include "qgpo_map.svh"
`default_nettype none

module tb_qgpo_gen;
    logic mclk, rst_b, three_mode, origin_en, alarm_line_en;
    logic pos_step, pos_extend, disturb, alarm_in, rx_clr, seen_err;
    logic [1:0] res_sel;
    logic [15:0] origin_pos;
    logic pha_p, pha_n, phb_p, phb_n, phz_p, phz_n, alarm_out, err_mode;
    logic rx_err, rx_pair_bad;
    logic [7:0] rx_min_gap;
    qgpo_pkg::qgpo_pos_t rx_cnt;
    int fails, n_tests, cyc;

    qgpo_gen qgpo_gen_i (.mclk(mclk), .rst_b(rst_b),
        .three_mode(three_mode), .res_sel(res_sel), .origin_en(origin_en),
        .alarm_line_en(alarm_line_en), .origin_pos(origin_pos),
        .pos_step(pos_step), .pos_extend(pos_extend), .disturb(disturb),
        .alarm_in(alarm_in), .pha_p(pha_p), .pha_n(pha_n), .phb_p(phb_p),
        .phb_n(phb_n), .phz_p(phz_p), .phz_n(phz_n),
        .alarm_out(alarm_out), .err_mode(err_mode));
    qgpo_rx_model qgpo_rx_model_i (.mclk(mclk), .rst_b(rst_b), .clr(rx_clr),
        .pha_p(pha_p), .pha_n(pha_n), .phb_p(phb_p), .phb_n(phb_n),
        .cnt(rx_cnt), .err_seen(rx_err), .pair_bad(rx_pair_bad),
        .min_gap(rx_min_gap));

    ////////////////////////////////////////////////////////////////////////
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    // Sticky error flag, cleared by each reset
    always @(posedge mclk)
    begin
        if (!rst_b)
            seen_err <= 1'b0;
        else if (err_mode === 1'b1)
            seen_err <= 1'b1;
    end

    // Whole run needs about 500 cycles
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            fails = fails + 1;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Line levels expected at a given count
    function automatic logic [1:0] ab_of(input int k);
        case (k % 4)
            0: ab_of = 2'h0;
            1: ab_of = 2'h2;
            2: ab_of = 2'h3;
            default: ab_of = 2'h1;
        endcase
    endfunction

    task automatic do_reset(input logic tm, input logic [1:0] rs);
        @(negedge mclk);
        rst_b = 1'b0;
        three_mode = tm;
        res_sel = rs;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
    endtask

    // Holds pos_step high across back-to-back steps
    task automatic steps(input logic ext, input int n, input int space);
        for (int i = 0; i < n; i++)
        begin
            pos_step = 1'b1;
            pos_extend = ext;
            @(negedge mclk);
            if (space > 0)
                pos_step = 1'b0;
            repeat (space) @(negedge mclk);
        end
        // Spaced steps are already low; an idle edge lets calls chain
        if (space == 0)
        begin
            pos_step = 1'b0;
            @(negedge mclk);
        end
    endtask

    task automatic wait_cnt(input logic [15:0] exp, input int lim);
        for (int i = 0; i < lim && rx_cnt !== exp; i++)
            @(negedge mclk);
        chk(rx_cnt, exp);
    endtask

    task automatic pulse_clr();
        rx_clr = 1'b1;
        @(negedge mclk);
        rx_clr = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        do_reset(1'b1, `QGPO_RES_0P5UM);
        chk(16'({pha_p, pha_n, phb_p, phb_n, phz_p, phz_n, alarm_out,
            err_mode}), 16'h0054);
    endtask

    task automatic t_direction();
        do_reset(1'b1, `QGPO_RES_1UM);
        for (int k = 1; k <= 4; k++)
        begin
            steps(1'b0, 1, 12);
            wait_cnt(16'(k), `QGPO_RT3_DLY_CYC);
            chk(16'({pha_p, phb_p}), 16'(ab_of(k)));
        end
        steps(1'b0, 2, 0);
        wait_cnt(16'h0006, `QGPO_RT3_DLY_CYC + `QGPO_TR_1_CYC);
        chk(16'(rx_min_gap >= `QGPO_TR_1_CYC), 16'h0001);
        for (int k = 5; k >= 2; k--)
        begin
            steps(1'b1, 1, 12);
            wait_cnt(16'(k), `QGPO_RT3_DLY_CYC);
            chk(16'({pha_p, phb_p}), 16'(ab_of(k)));
        end
        chk(16'({rx_pair_bad, rx_err}), 16'h0000);
    endtask

    task automatic t_burst();
        do_reset(1'b1, `QGPO_RES_0P5UM);
        steps(1'b0, 8, 0);
        wait_cnt(16'h0008, `QGPO_BST1_DLY_CYC);
        chk(16'(rx_min_gap < `QGPO_TR_0P5_CYC), 16'h0001);
        chk(16'(rx_min_gap >= `QGPO_TB_CYC), 16'h0001);
        chk(16'({seen_err, rx_err}), 16'h0000);
        do_reset(1'b1, `QGPO_RES_5UM);
        // Six out, four back with no idle cycle, so the gap sees a reversal
        for (int i = 0; i < 10; i++)
        begin
            pos_step = 1'b1;
            pos_extend = (i >= 6);
            @(negedge mclk);
        end
        pos_step = 1'b0;
        wait_cnt(16'h0002, `QGPO_BST2_DLY_CYC);
        chk(16'({seen_err, rx_err}), 16'h0000);
    endtask

    task automatic t_two_mode();
        do_reset(1'b0, `QGPO_RES_1UM);
        steps(1'b0, 3, 8);
        wait_cnt(16'h0003, `QGPO_RT2_DLY_CYC);
        chk(16'(rx_min_gap >= `QGPO_TR_1_CYC), 16'h0001);
        chk(16'(seen_err), 16'h0000);
        steps(1'b0, 40, 0);
        repeat (4) @(negedge mclk);
        chk(16'(seen_err), 16'h0001);
    endtask

    task automatic t_disturb();
        do_reset(1'b1, `QGPO_RES_0P5UM);
        disturb = 1'b1;
        repeat (2) @(negedge mclk);
        chk(16'(err_mode), 16'h0001);
        pulse_clr();
        repeat (20)
        begin
            @(negedge mclk);
            chk(16'(pha_p === phb_p), 16'h0001);
        end
        chk(16'(rx_err), 16'h0001);
        chk(16'(rx_min_gap >= `QGPO_TE_CYC), 16'h0001);
        disturb = 1'b0;
        repeat (10) @(negedge mclk);
        chk(16'(err_mode), 16'h0000);
    endtask

    task automatic t_alarm();
        do_reset(1'b1, `QGPO_RES_0P5UM);
        alarm_line_en = 1'b1;
        alarm_in = 1'b1;
        repeat (2) @(negedge mclk);
        chk(16'({alarm_out, err_mode}), 16'h0003);
        alarm_line_en = 1'b0;
        repeat (2) @(negedge mclk);
        chk(16'(alarm_out), 16'h0000);
        alarm_in = 1'b0;
        repeat (10) @(negedge mclk);
        chk(16'(err_mode), 16'h0000);
    endtask

    task automatic t_origin();
        origin_en = 1'b1;
        origin_pos = 16'h0002;
        do_reset(1'b1, `QGPO_RES_1UM);
        chk(16'({phz_p, phz_n}), 16'h0001);
        steps(1'b0, 2, 12);
        wait_cnt(16'h0002, `QGPO_RT3_DLY_CYC);
        chk(16'({phz_p, phz_n}), 16'h0002);
        steps(1'b0, 1, 12);
        chk(16'({phz_p, phz_n}), 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        fails = 0;
        n_tests = 0;
        cyc = 0;
        rst_b = 1'b0;
        three_mode = 1'b1;
        res_sel = `QGPO_RES_0P5UM;
        origin_en = 1'b0;
        alarm_line_en = 1'b0;
        origin_pos = 16'h0000;
        pos_step = 1'b0;
        pos_extend = 1'b0;
        disturb = 1'b0;
        alarm_in = 1'b0;
        rx_clr = 1'b0;
        t_reset();
        t_direction();
        t_burst();
        t_two_mode();
        t_disturb();
        t_alarm();
        t_origin();
        end_of_test();
    end
endmodule

`default_nettype wire
